// ---- wpl_pkg.sv ----
// Constants, types and helpers shared by the watchdog control block.
package wpl_pkg;

    // System clock and the emulated slow watchdog clock.
    localparam int CLK_PERIOD_NS = 4;
    localparam int WDT_TICK_NS   = 1000000;
    localparam int TICK_CYCLES   = WDT_TICK_NS / CLK_PERIOD_NS;

    // Protected-write gate stays open for this many system cycles.
    localparam int GATE_CYCLES   = 4;
    // Watchdog clock ticks needed to carry a control value across.
    localparam int SYNC_TICKS    = 2;

    // Register indexes; byte address is four times the index.
    localparam logic [5:0] CTRL_IDX = 6'h00;
    localparam logic [5:0] STAT_IDX = 6'h01;
    localparam logic [5:0] GATE_IDX = 6'h02;

    // Field positions.
    localparam int PERIOD_LSB = 0;
    localparam int WINDOW_LSB = 4;
    localparam int CODE_W     = 4;
    localparam int LOCK_BIT   = 7;
    localparam int BUSY_BIT   = 0;

    // Reset values.
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Code table: zero is off, one to eleven double from 8 ticks.
    localparam logic [3:0]  CODE_OFF = 4'h0;
    localparam logic [3:0]  CODE_MIN = 4'h1;
    localparam logic [3:0]  CODE_MAX = 4'hB;
    localparam int          CNT_W    = 14;
    localparam logic [13:0] BASE_LEN = 14'h0008;

    // Unlock key value is arbitrary.
    localparam logic [7:0] GATE_KEY = 8'h5C;

    typedef enum logic [1:0] {
        WPL_IDLE   = 2'b00,
        WPL_OPEN   = 2'b01,
        WPL_CLOSED = 2'b11,
        WPL_FIRE   = 2'b10
    } wpl_phase_t;

    // Length in watchdog ticks; reserved codes saturate at the longest.
    function automatic logic [13:0] code_len(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        if (c == CODE_OFF) begin
            return 14'h0000;
        end
        return BASE_LEN << (c - CODE_MIN);
    endfunction

endpackage

// ---- wpl_wdog_core.sv ----
// Watchdog counter running on the slow tick enable.
`timescale 1ns/1ps
`default_nettype none
module wpl_wdog_core (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Slow clock enable and controls
    input  wire logic       tick,
    input  wire logic       halt,
    input  wire logic [3:0] period_code,
    input  wire logic [3:0] window_code,
    input  wire logic       clear_req,
    // Status
    output var  logic       bark,
    output var  logic       active
);
    wpl_pkg::wpl_phase_t phase_r;
    logic [13:0]         cnt_r;
    logic                clr_pend_r;
    logic [13:0]         cnt_inc;
    logic [13:0]         per_len;
    logic [13:0]         win_len;

    assign cnt_inc = cnt_r + 14'h0001;
    assign per_len = wpl_pkg::code_len(period_code);
    assign win_len = wpl_pkg::code_len(window_code);

    // A clear waits for the next tick; one landing on a tick is kept.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr_pend_r <= 1'b0;
        end else if (halt) begin
            clr_pend_r <= 1'b0;
        end else if (clear_req) begin
            clr_pend_r <= 1'b1;
        end else if (tick) begin
            clr_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= wpl_pkg::WPL_IDLE;
            cnt_r   <= 14'h0000;
        end else if (phase_r == wpl_pkg::WPL_FIRE) begin
            phase_r <= wpl_pkg::WPL_FIRE;
        end else if (halt) begin
            phase_r <= wpl_pkg::WPL_IDLE;
            cnt_r   <= 14'h0000;
        end else if (tick) begin
            if (period_code == wpl_pkg::CODE_OFF) begin
                phase_r <= wpl_pkg::WPL_IDLE;
                cnt_r   <= 14'h0000;
            end else begin
                case (phase_r)
                    wpl_pkg::WPL_IDLE: begin
                        phase_r <= wpl_pkg::WPL_OPEN;
                        cnt_r   <= 14'h0000;
                    end
                    wpl_pkg::WPL_CLOSED: begin
                        if (clr_pend_r) begin
                            phase_r <= wpl_pkg::WPL_FIRE;
                        end else if (cnt_inc >= win_len) begin
                            phase_r <= wpl_pkg::WPL_OPEN;
                            cnt_r   <= 14'h0000;
                        end else begin
                            cnt_r <= cnt_inc;
                        end
                    end
                    wpl_pkg::WPL_OPEN: begin
                        if (clr_pend_r) begin
                            cnt_r <= 14'h0000;
                            if (window_code != wpl_pkg::CODE_OFF) begin
                                phase_r <= wpl_pkg::WPL_CLOSED;
                            end
                        end else if (cnt_inc >= per_len) begin
                            phase_r <= wpl_pkg::WPL_FIRE;
                        end else begin
                            cnt_r <= cnt_inc;
                        end
                    end
                    default: begin
                        phase_r <= wpl_pkg::WPL_FIRE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bark   <= 1'b0;
            active <= 1'b0;
        end else begin
            bark   <= (phase_r == wpl_pkg::WPL_FIRE);
            active <= (period_code != wpl_pkg::CODE_OFF);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_open_expiry: assert property (
        tick && !halt && phase_r == wpl_pkg::WPL_OPEN && !clr_pend_r
        && period_code != wpl_pkg::CODE_OFF && cnt_inc >= per_len
        |=> phase_r == wpl_pkg::WPL_FIRE ##1 bark)
        else $error("open window expiry did not raise reset");

    a_closed_clear: assert property (
        tick && !halt && phase_r == wpl_pkg::WPL_CLOSED && clr_pend_r
        && period_code != wpl_pkg::CODE_OFF
        |=> ##1 bark)
        else $error("clear in closed window did not raise reset");

endmodule
`default_nettype wire

// ---- wpl_top.sv ----
// Watchdog control, freeze and crossing status behind an APB slave.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module wpl_top #(
    parameter int ADDR_W      = 8,
    parameter int TICK_CYCLES = wpl_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // System side
    input  wire logic [7:0]        fuse_cfg,
    input  wire logic              boot_done,
    input  wire logic              debug_mode,
    input  wire logic              watchdog_clear_instr,
    output var  logic              watchdog_reset,
    output var  logic              watchdog_active
);
    localparam int DIV_W = $clog2(TICK_CYCLES + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
    localparam logic [2:0] GATE_LOAD = 3'(wpl_pkg::GATE_CYCLES);
    localparam logic [1:0] SYNC_LAST = 2'(wpl_pkg::SYNC_TICKS - 1);

    logic [DIV_W-1:0] div_cnt_r;
    logic             tick_r;
    logic [2:0]       gate_cnt_r;
    logic [7:0]       ctrl_r;
    logic             lock_r;
    logic             busy_r;
    logic [1:0]       sync_cnt_r;
    logic [3:0]       run_period_r;
    logic [3:0]       run_window_r;
    logic             boot_load_r;
    logic             boot_seen_r;
    logic             core_bark;
    logic             core_active;
    logic [31:0]      rd_nxt;

    logic [5:0] idx;
    logic       aligned;
    logic       mapped;
    logic       wr_fire;
    logic       gate_open;
    logic       ctrl_take;
    logic       lock_set;
    logic       lock_clr;
    logic       boot_rise;
    logic       sync_done;

    assign idx       = paddr[7:2];
    assign aligned   = (paddr[1:0] == 2'b00);
    assign mapped    = aligned && (idx == wpl_pkg::CTRL_IDX
                                   || idx == wpl_pkg::STAT_IDX
                                   || idx == wpl_pkg::GATE_IDX);
    assign wr_fire   = psel && penable && pready && pwrite && mapped;
    assign gate_open = (gate_cnt_r != 3'h0);
    assign boot_rise = boot_done && !boot_seen_r;
    assign sync_done = busy_r && tick_r && (sync_cnt_r == SYNC_LAST);

    // Frozen or ungated control writes refused.
    assign ctrl_take = wr_fire && idx == wpl_pkg::CTRL_IDX && gate_open
                       && !lock_r;
    // Freeze bit writes pass the gate.
    assign lock_set  = wr_fire && idx == wpl_pkg::STAT_IDX && gate_open
                       && pwdata[wpl_pkg::LOCK_BIT];
    // Zero write clears freeze only in debug.
    assign lock_clr  = wr_fire && idx == wpl_pkg::STAT_IDX && gate_open
                       && !pwdata[wpl_pkg::LOCK_BIT] && debug_mode;

    // Slow watchdog clock is a one-cycle enable from this divider.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_r <= '0;
            tick_r    <= 1'b0;
        end else if (div_cnt_r == DIV_LAST) begin
            div_cnt_r <= '0;
            tick_r    <= 1'b1;
        end else begin
            div_cnt_r <= div_cnt_r + DIV_W'(1);
            tick_r    <= 1'b0;
        end
    end

    // Key opens the gate for a few cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_cnt_r <= 3'h0;
        end else if (wr_fire && idx == wpl_pkg::GATE_IDX) begin
            gate_cnt_r <= (pwdata[7:0] == wpl_pkg::GATE_KEY) ? GATE_LOAD
                                                              : 3'h0;
        end else if (wr_fire && idx != wpl_pkg::GATE_IDX) begin
            gate_cnt_r <= 3'h0;
        end else if (gate_open) begin
            gate_cnt_r <= gate_cnt_r - 3'h1;
        end
    end

    // Boot value is caught from the fuses on the first edge after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_load_r <= 1'b0;
            boot_seen_r <= 1'b0;
        end else begin
            boot_load_r <= 1'b1;
            boot_seen_r <= boot_done;
        end
    end

    // Control holds period and window codes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= wpl_pkg::CTRL_RESET;
        end else if (!boot_load_r) begin
            ctrl_r <= fuse_cfg;
        end else if (ctrl_take) begin
            ctrl_r <= pwdata[7:0];
        end
    end

    // Set by software or boot; set wins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= wpl_pkg::STAT_RESET[wpl_pkg::LOCK_BIT];
        end else if (lock_set) begin
            lock_r <= 1'b1;
        // Boot end with live period freezes.
        end else if (boot_rise
                     && ctrl_r[wpl_pkg::PERIOD_LSB +: wpl_pkg::CODE_W]
                        != wpl_pkg::CODE_OFF) begin
            lock_r <= 1'b1;
        end else if (lock_clr) begin
            lock_r <= 1'b0;
        end
    end

    // Busy rises on each accepted control value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r     <= wpl_pkg::STAT_RESET[wpl_pkg::BUSY_BIT];
            sync_cnt_r <= 2'h0;
        end else if (ctrl_take || !boot_load_r) begin
            busy_r     <= 1'b1;
            sync_cnt_r <= 2'h0;
        // Busy falls once the value has crossed.
        end else if (sync_done) begin
            busy_r     <= 1'b0;
            sync_cnt_r <= 2'h0;
        end else if (busy_r && tick_r) begin
            sync_cnt_r <= sync_cnt_r + 2'h1;
        end
    end

    // Running codes update only at crossing end.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_period_r <= wpl_pkg::CODE_OFF;
            run_window_r <= wpl_pkg::CODE_OFF;
        end else if (sync_done && !ctrl_take) begin
            run_period_r <= ctrl_r[wpl_pkg::PERIOD_LSB +: wpl_pkg::CODE_W];
            run_window_r <= ctrl_r[wpl_pkg::WINDOW_LSB +: wpl_pkg::CODE_W];
        end
    end

    // Code table applied in the counter.
    wpl_wdog_core u_core (
        .pclk        (pclk),
        .presetn     (presetn),
        .tick        (tick_r),
        .halt        (debug_mode),
        .period_code (run_period_r),
        .window_code (run_window_r),
        .clear_req   (watchdog_clear_instr),
        .bark        (core_bark),
        .active      (core_active)
    );

    // Busy is read without the gate.
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (idx == wpl_pkg::CTRL_IDX) begin
            rd_nxt[7:0] = ctrl_r;
        end else if (idx == wpl_pkg::STAT_IDX) begin
            rd_nxt[wpl_pkg::LOCK_BIT] = lock_r;
            rd_nxt[wpl_pkg::BUSY_BIT] = busy_r;
        end
    end

    // Answers are registered in setup, so every access has no wait state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite && mapped) begin
                prdata <= rd_nxt;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reset  <= 1'b0;
            watchdog_active <= 1'b0;
        end else begin
            watchdog_reset  <= core_bark;
            watchdog_active <= core_active;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_lock_no_clear: assert property (
        $fell(lock_r) |-> $past(debug_mode))
        else $error("freeze bit cleared outside debug");

    a_lock_one_only: assert property (
        lock_r && !debug_mode |=> lock_r)
        else $error("freeze bit dropped by a write");

    a_ctrl_frozen: assert property (
        lock_r && boot_load_r |=> $stable(ctrl_r))
        else $error("control changed while frozen");

    a_ctrl_gated: assert property (
        boot_load_r && !gate_open |=> $stable(ctrl_r) && !$rose(lock_r)
            || $past(boot_rise))
        else $error("protected bits changed without the gate");

    a_busy_rise: assert property (
        ctrl_take |=> busy_r && sync_cnt_r == 2'h0)
        else $error("busy not raised after control write");

    a_busy_fall: assert property (
        sync_done && !ctrl_take |=> !busy_r)
        else $error("busy not cleared after crossing");

    a_codes_held: assert property (
        !$past(sync_done) |-> $stable(run_period_r) && $stable(run_window_r))
        else $error("running codes changed before crossing end");

    a_boot_freeze: assert property (
        boot_rise && ctrl_r[3:0] != wpl_pkg::CODE_OFF |=> lock_r)
        else $error("freeze not set after boot");

    a_active_map: assert property (
        run_period_r != wpl_pkg::CODE_OFF |-> ##2 watchdog_active)
        else $error("watchdog not active for non-zero period");

endmodule
`default_nettype wire

// ---- watchdog_period_lock_status_test.sv ----
// Self-checking testbench for the watchdog control, freeze and busy block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end

module watchdog_period_lock_status_test;
    // Short tick so that the longest code still fits the run.
    localparam int         T      = 4;
    localparam logic [7:0] A_CTRL = {wpl_pkg::CTRL_IDX, 2'b00};
    localparam logic [7:0] A_STAT = {wpl_pkg::STAT_IDX, 2'b00};
    localparam logic [7:0] A_GATE = {wpl_pkg::GATE_IDX, 2'b00};

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  fuse_cfg;
    logic        boot_done;
    logic        debug_mode;
    logic        clr;
    logic        wd_rst;
    logic        wd_act;
    logic [7:0]  rd;
    logic        er;
    int          err_count;
    int          compares;

    wpl_top #(.ADDR_W(8), .TICK_CYCLES(T)) DUT (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .fuse_cfg             (fuse_cfg),
        .boot_done            (boot_done),
        .debug_mode           (debug_mode),
        .watchdog_clear_instr (clr),
        .watchdog_reset       (wd_rst),
        .watchdog_active      (wd_act)
    );

    always #2 pclk = ~pclk;

    task automatic apb_setup(input logic w, input logic [7:0] a,
                             input logic [7:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
    endtask

    // The request is held until pready is seen high at a rising edge.
    task automatic apb_access(output logic [7:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            $display("BAD t=%0t no pready", $time);
        end
        r = prdata[7:0];
        e = pslverr;
    endtask

    task automatic apb_end();
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] r,
                          output logic e);
        @(posedge pclk);
        apb_setup(1'b0, a, 8'h00);
        apb_access(r, e);
        apb_end();
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        @(posedge pclk);
        apb_setup(1'b1, a, d);
        apb_access(r, e);
        apb_end();
    endtask

    // Key then write
    // The protected write follows the key with no idle cycle between.
    task automatic prot(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       e;
        @(posedge pclk);
        apb_setup(1'b1, A_GATE, wpl_pkg::GATE_KEY);
        apb_access(r, e);
        apb_setup(1'b1, a, d);
        apb_access(r, e);
        apb_end();
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] x);
        rd_reg(a, rd, er);
        `CHK(rd, x)
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            rd_reg(A_STAT, rd, er);
            n++;
        end while (rd[0] !== 1'b0 && n < 64);
        `CHK(rd[0], 1'b0)
    endtask

    task automatic pulse_clr();
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
    endtask

    task automatic rst(input logic [7:0] f);
        @(posedge pclk);
        presetn    <= 1'b0;
        fuse_cfg   <= f;
        boot_done  <= 1'b0;
        debug_mode <= 1'b0;
        clr        <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        boot_done <= 1'b1;
    endtask

    task automatic t_map();
        rst(8'h00);
        wait_idle();
        chk_reg(A_CTRL, 8'h00);
        chk_reg(A_STAT, 8'h00);
        chk_reg(A_GATE, 8'h00);
        rd_reg(8'hFC, rd, er);
        `CHK(er, 1'b1)
        rd_reg(8'h01, rd, er);
        `CHK(er, 1'b1)
        `CHK(wd_act, 1'b0)
    endtask

    task automatic t_protect();
        rst(8'h00);
        wait_idle();
        wr_reg(A_STAT, 8'h01);
        chk_reg(A_STAT, 8'h00);
        wr_reg(A_CTRL, 8'h01);
        wait_idle();
        chk_reg(A_CTRL, 8'h00);
        prot(A_CTRL, 8'h01);
        rd_reg(A_STAT, rd, er);
        `CHK(rd[0], 1'b1)
        `CHK(wd_act, 1'b0)
        wait_idle();
        repeat (2) @(posedge pclk);
        `CHK(wd_act, 1'b1)
        repeat (12) begin
            repeat (3 * T) @(posedge pclk);
            pulse_clr();
        end
        `CHK(wd_rst, 1'b0)
        repeat (14 * T) @(posedge pclk);
        `CHK(wd_rst, 1'b1)
    endtask

    task automatic t_freeze();
        rst(8'h00);
        wait_idle();
        prot(A_CTRL, 8'h02);
        wait_idle();
        prot(A_STAT, 8'h80);
        chk_reg(A_STAT, 8'h80);
        prot(A_CTRL, 8'h05);
        wait_idle();
        chk_reg(A_CTRL, 8'h02);
        prot(A_STAT, 8'h00);
        chk_reg(A_STAT, 8'h80);
        @(posedge pclk);
        debug_mode <= 1'b1;
        prot(A_STAT, 8'h00);
        chk_reg(A_STAT, 8'h00);
        @(posedge pclk);
        debug_mode <= 1'b0;
        prot(A_CTRL, 8'h05);
        wait_idle();
        chk_reg(A_CTRL, 8'h05);
    endtask

    task automatic t_boot();
        rst(8'h02);
        wait_idle();
        chk_reg(A_STAT, 8'h80);
        prot(A_CTRL, 8'h00);
        wait_idle();
        chk_reg(A_CTRL, 8'h02);
    endtask

    // Window mode: a clear inside the closed part fires the reset.
    task automatic t_window();
        rst(8'h00);
        wait_idle();
        prot(A_CTRL, 8'h11);
        wait_idle();
        repeat (2 * T) @(posedge pclk);
        pulse_clr();
        repeat (3 * T) @(posedge pclk);
        `CHK(wd_rst, 1'b0)
        pulse_clr();
        repeat (4 * T) @(posedge pclk);
        `CHK(wd_rst, 1'b1)
    endtask

    // Time from start of counting to the reset tracks the code table.
    task automatic t_period(input logic [3:0] code);
        int len;
        int n;
        len = 8 << (code - 1);
        rst(8'h00);
        wait_idle();
        prot(A_CTRL, {4'h0, code});
        n = 0;
        while (wd_act !== 1'b1 && n < 100) begin
            @(posedge pclk);
            n++;
        end
        n = 0;
        while (wd_rst !== 1'b1 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        `CHK((n >= len * T) && (n <= (len + 2) * T + 8), 1'b1)
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        pclk       = 1'b0;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h00000000;
        fuse_cfg   = 8'h00;
        boot_done  = 1'b0;
        debug_mode = 1'b0;
        clr        = 1'b0;
        err_count  = 0;
        compares   = 0;
        t_map();
        t_protect();
        t_freeze();
        t_boot();
        t_window();
        t_period(4'h1);
        t_period(4'h2);
        t_period(4'h3);
        t_period(4'hB);
        final_report();
    end

    // Whole run needs well under this; a hang ends here.
    initial begin
        #400000;
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
